/* core/plmc_fifo.sv */
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/100ps
module plmc_fifo #(
   parameter int W = 5,
   parameter int D = 4
) (
   input wire logic clk, // clock
   input wire logic srst, // synchronous reset
   plmc_fifo_if.dst wr, // filling side
   output logic out_valid, // data available
   input wire logic out_ready, // draining side ready
   output logic [W-1:0] out_data // registered head word
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp, rp;
      logic [AW:0] cnt;
      logic [W-1:0] head;
   } plmc_fifo_s;
   plmc_fifo_s s, next_s;
   logic push, pop;

   // pointer step with wrap, depth need not be a power of two
   function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
      return (p == AW'(D-1)) ? '0 : p + 1'b1;
   endfunction

   // full and empty straight from the count
   assign wr.ready = (s.cnt != D[AW:0]);
   assign out_valid = (s.cnt != '0);
   assign push = wr.valid && wr.ready;
   assign pop = out_valid && out_ready;
   assign out_data = s.head;
   // head word kept registered; bypass when empty saves a cycle
   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wp] = wr.data;
         next_s.wp = step(s.wp);
      end
      if (pop) begin
         next_s.rp = step(s.rp);
      end
      next_s.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      if (pop && s.cnt > 1) begin
         next_s.head = s.mem[step(s.rp)];
      end else if (push && (s.cnt == 0 || (pop && s.cnt == 1))) begin
         next_s.head = wr.data;
      end
      if (srst) begin
         next_s = '0;
      end
   end
   always_ff @(posedge clk) begin
      s <= next_s;
   end
endmodule // plmc_fifo

/* core/plmc_fifo_if.sv */
// carrier between producer and fifo for 5b line codes
`timescale 1ns/100ps
interface plmc_fifo_if #(parameter int W = 5);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface

/* core/plmc_params.svh */
// constants for the line mode and loopback control block
`ifndef PLMC_PARAMS_SVH
`define PLMC_PARAMS_SVH
`define PLMC_ADDR_BMC 16'h0000
`define PLMC_ADDR_CR1 16'h0009
`define PLMC_ADDR_STL 16'h0016
`define PLMC_ADDR_PHC 16'h0019
`define PLMC_ADDR_FGC 16'h0465
`define PLMC_BMC_LOOP 14
`define PLMC_BMC_ANEN 12
`define PLMC_CR1_FASTX 6
`define PLMC_PHC_AXEN 15
`define PLMC_PHC_XSEL 14
`define PLMC_FGC_SDPOL 0
`define PLMC_STL_PCSI 0
`define PLMC_STL_PCSO 1
`define PLMC_STL_DIG 2
`define PLMC_STL_ANA 3
`define PLMC_STL_FAR 4
`define PLMC_BMC_RST 16'h0000
`define PLMC_CR1_RST 16'h0000
`define PLMC_STL_RST 16'h0000
`define PLMC_PHC_RST 16'h0000
`define PLMC_FGC_RST 16'h0000
`define PLMC_CLK_MHZ 20
`define PLMC_SQ_NS 50
`define PLMC_SQ_CYC ((`PLMC_SQ_NS * `PLMC_CLK_MHZ + 999) / 1000)
`define PLMC_LP_NS 100
`define PLMC_LP_CYC ((`PLMC_LP_NS * `PLMC_CLK_MHZ) / 1000)
`define PLMC_LPI_MS 16
`define PLMC_LPI_CYC (`PLMC_LPI_MS * `PLMC_CLK_MHZ * 1000)
`define PLMC_JAB_MS 100
`define PLMC_JAB_CYC (`PLMC_JAB_MS * `PLMC_CLK_MHZ * 1000)
`define PLMC_UNJ_MS 500
`define PLMC_UNJ_CYC (`PLMC_UNJ_MS * `PLMC_CLK_MHZ * 1000)
`define PLMC_XOVR_CYC 1024
`define PLMC_XOVR_FAST 128
`define PLMC_SQ_TRANS 5
`define PLMC_POL_CNT 3
`define PLMC_FIFO_DEPTH 4
`endif

/* core/plmc_pkg.sv */
// types for the line mode and loopback control block
package plmc_pkg;
   typedef enum logic [2:0] {
      SQ_IDLE = 3'b000,
      SQ_FIRST = 3'b001,
      SQ_OPP = 3'b011,
      SQ_VALID = 3'b010
   } plmc_sq_e;
   typedef enum logic [1:0] {
      JB_OK = 2'b00,
      JB_CUT = 2'b01,
      JB_UNJAB = 2'b11
   } plmc_jb_e;
   typedef enum logic [2:0] {
      LB_NONE = 3'b000,
      LB_MII = 3'b001,
      LB_PCSI = 3'b011,
      LB_PCSO = 3'b010,
      LB_DIG = 3'b110,
      LB_ANA = 3'b111,
      LB_FAR = 3'b101
   } plmc_lb_e;
endpackage

/* core/plmc_top.sv */
// line mode, 10 Mb/s timing, crossover and loopback control
`timescale 1ns/100ps
`include "plmc_params.svh"
module plmc_top
   import plmc_pkg::*;
#(
   parameter int LPI_CYC = `PLMC_LPI_CYC, // link pulse interval
   parameter int JAB_CYC = `PLMC_JAB_CYC, // jabber limit
   parameter int UNJ_CYC = `PLMC_UNJ_CYC // unjab wait
) (
   input wire logic CLK, // 20 MHz clock
   input wire logic SRST, // sync reset, active high
   input wire logic [1:0] FIBER_MODE_STRAP, // 4-level strap code 0..3
   input wire logic [1:0] CROSSOVER_STRAP, // 4-level strap code 0..3
   input wire logic AUTONEG_STRAP, // negotiation strap
   input wire logic REG_WR, // register write strobe
   input wire logic [15:0] REG_ADDR, // register address
   input wire logic [15:0] REG_WDATA, // write data
   output logic [15:0] REG_RDATA, // read data of REG_ADDR
   input wire logic SPEED_100, // current speed is 100 Mb/s
   input wire logic MAC_TX_EN, // mac transmit enable
   input wire logic [3:0] MAC_TXD, // mac transmit nibble
   output logic MAC_RX_DV, // looped receive valid
   output logic [3:0] MAC_RXD, // looped receive nibble
   output logic [4:0] TX_CODE, // 5b code to serializer
   output logic TX_CODE_VALID, // code strobe
   input wire logic TX_CODE_READY, // serializer takes code
   output logic TX_FULL, // code fifo refuses more
   input wire logic SECOND_LED_PIN_I, // second led pin input
   output logic SECOND_LED_PIN_O, // second led pin output
   output logic SECOND_LED_PIN_OE, // drives second led pin
   output logic SIGNAL_DETECT, // fiber signal present
   input wire logic SQ_POS, // positive squelch crossing
   input wire logic SQ_NEG, // negative squelch crossing
   output logic RX_VALID_10, // 10M receive data valid
   output logic POL_REVERSED, // 10M pair reversed
   output logic LINK_PULSE, // 10M link pulse out
   output logic TX_ALLOWED, // transmitter outputs on
   output logic JABBER, // jabber cut-off active
   output logic BYPASS_SCRAMBLE, // skip scrambler and descrambler
   output logic BYPASS_MLT3, // skip three-level coder
   output logic AN_ENABLE, // negotiation running
   output logic [1:0] AN_ABILITY, // offered: bit1 100TX, bit0 10
   output logic MDI_CROSS, // pair assignment crossover
   output logic XOVR_DONE, // crossover resolved
   output logic [2:0] LOOP_MODE // active loopback point
);
   typedef struct packed {
      logic [15:0] bmc, cr1, stl, phc, fgc;
      logic [1:0] fx_s, sd_s;
      logic started;
      logic [2:0] led_sync, sqp_sync, sqn_sync;
      plmc_sq_e sq;
      logic sq_pol;
      logic [7:0] sq_cnt;
      logic [2:0] trans;
      logic [1:0] pol_cnt;
      logic pol_rev;
      logic [31:0] lp_cnt;
      logic [3:0] lp_w;
      plmc_jb_e jb;
      logic [31:0] jb_cnt;
      logic [10:0] xo_cnt;
      logic xo_sel;
      logic [3:0] rxd;
      logic rxdv;
   } plmc_st_s;
   plmc_st_s r, next_r;
   plmc_fifo_if #(.W(5)) fif ();
   logic fiber_mode_strap, signal_detect_strap, wr_hit_bmc;

   function automatic logic [4:0] enc4b5b(input logic [3:0] n);
      logic [4:0] t [16];
      t = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
            5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
      return t[n];
   endfunction

   function automatic logic [15:0] reg_wr(input logic [15:0] old,
         input logic [15:0] a, input logic [15:0] me);
      return (REG_WR && a == me) ? REG_WDATA : old;
   endfunction

   // fiber mode from strap levels 2 or 3 (codes 1,2); sd strap 3,4
   assign fiber_mode_strap = (r.fx_s == 2'h1) || (r.fx_s == 2'h2);
   assign signal_detect_strap = fiber_mode_strap && (r.sd_s == 2'h2 || r.sd_s == 2'h3);
   assign wr_hit_bmc = REG_WR && REG_ADDR == `PLMC_ADDR_BMC;

   // no nibble is taken while a link pulse holds the line
   assign fif.valid = MAC_TX_EN && r.lp_w == '0;
   assign fif.data = enc4b5b(MAC_TXD);
   assign TX_FULL = !fif.ready;

   plmc_fifo #(.W(5), .D(`PLMC_FIFO_DEPTH)) u_fifo (
      .clk(CLK),
      .srst(SRST),
      .wr(fif),
      .out_valid(TX_CODE_VALID),
      .out_ready(TX_CODE_READY && TX_ALLOWED),
      .out_data(TX_CODE)
   );

   // next state of everything
   always_comb begin
      logic cross_first, cross_opp, any_cross, tx_act;
      cross_first = 1'b0;
      cross_opp = 1'b0;
      any_cross = 1'b0;
      tx_act = 1'b0;
      next_r = r;
      // registers; straps caught one cycle after reset release
      next_r.bmc = reg_wr(r.bmc, REG_ADDR, `PLMC_ADDR_BMC);
      next_r.cr1 = reg_wr(r.cr1, REG_ADDR, `PLMC_ADDR_CR1);
      next_r.stl = reg_wr(r.stl, REG_ADDR, `PLMC_ADDR_STL);
      next_r.phc = reg_wr(r.phc, REG_ADDR, `PLMC_ADDR_PHC);
      next_r.fgc = reg_wr(r.fgc, REG_ADDR, `PLMC_ADDR_FGC);
      if (!r.started) begin
         next_r.started = 1'b1;
         next_r.fx_s = FIBER_MODE_STRAP;
         next_r.sd_s = CROSSOVER_STRAP;
         next_r.bmc[`PLMC_BMC_ANEN] = AUTONEG_STRAP;
         next_r.phc[`PLMC_PHC_AXEN] = CROSSOVER_STRAP[1];
         next_r.phc[`PLMC_PHC_XSEL] = CROSSOVER_STRAP[0];
      end
      // one loopback: a new selftest write clears mii loop, and back
      if (REG_WR && REG_ADDR == `PLMC_ADDR_STL && REG_WDATA[4:0] != 0)
      begin
         next_r.bmc[`PLMC_BMC_LOOP] = 1'b0;
      end
      if (wr_hit_bmc && REG_WDATA[`PLMC_BMC_LOOP]) begin
         next_r.stl[4:0] = 5'h00;
      end
      // synchronisers; stage 0 read only by stage 1
      next_r.led_sync = {r.led_sync[1:0], SECOND_LED_PIN_I};
      next_r.sqp_sync = {r.sqp_sync[1:0], SQ_POS};
      next_r.sqn_sync = {r.sqn_sync[1:0], SQ_NEG};
      // squelch qualification, polarity-aware
      cross_first = r.sq_pol ? r.sqn_sync[1] : r.sqp_sync[1];
      cross_opp = r.sq_pol ? r.sqp_sync[1] : r.sqn_sync[1];
      any_cross = (r.sqp_sync[1] && !r.sqp_sync[2]) ||
                  (r.sqn_sync[1] && !r.sqn_sync[2]);
      tx_act = MAC_TX_EN && TX_ALLOWED;
      // spacing timer between crossings runs down to zero
      if (r.sq_cnt != 8'h00) begin
         next_r.sq_cnt = r.sq_cnt - 8'h01;
      end
      unique case (r.sq)
         SQ_IDLE: begin
            next_r.trans = 3'h0;
            if (cross_first) begin
               next_r.sq = SQ_FIRST;
               next_r.sq_cnt = 8'(`PLMC_SQ_CYC);
            end else if (cross_opp) begin
               // first pulse of wrong sign counts toward reversal
               next_r.pol_cnt = r.pol_cnt + 2'h1;
            end
         end
         SQ_FIRST: begin
            if (cross_opp && r.sq_cnt == 0) begin
               next_r.sq = SQ_OPP;
               next_r.sq_cnt = 8'(`PLMC_SQ_CYC);
            end else if (cross_opp) begin
               next_r.sq = SQ_IDLE; // too early, reject
            end
         end
         SQ_OPP: begin
            if (cross_first && r.sq_cnt == 0) begin
               next_r.sq = SQ_VALID;
            end else if (cross_first) begin
               next_r.sq = SQ_IDLE;
            end
         end
         SQ_VALID: begin
            if (tx_act && any_cross) begin
               next_r.trans = r.trans + 3'h1;
            end
            if (!r.sqp_sync[1] && !r.sqn_sync[1] && !any_cross) begin
               next_r.sq = SQ_IDLE;
            end
            if (tx_act && r.trans == 3'(`PLMC_SQ_TRANS - 1) && any_cross)
            begin
               next_r.sq = SQ_IDLE;
            end
         end
         default: next_r.sq = SQ_IDLE;
      endcase
      if (r.pol_cnt == 2'(`PLMC_POL_CNT)) begin
         next_r.sq_pol = !r.sq_pol;
         next_r.pol_cnt = 2'h0;
      end
      if (r.sq == SQ_VALID) begin
         next_r.pol_cnt = 2'h0;
      end
      // squelch only matters at 10 Mb/s
      if (SPEED_100) begin
         next_r.sq = SQ_IDLE;
      end
      // link pulses while idle at 10M
      if (r.lp_w != 4'h0) begin
         next_r.lp_w = r.lp_w - 4'h1;
      end
      if (SPEED_100 || MAC_TX_EN || fiber_mode_strap) begin
         next_r.lp_cnt = 32'h0;
      end else if (r.lp_cnt == 32'(LPI_CYC - 1)) begin
         next_r.lp_cnt = 32'h0;
         next_r.lp_w = 4'(`PLMC_LP_CYC);
      end else begin
         next_r.lp_cnt = r.lp_cnt + 32'h1;
      end
      // jabber, 10M only
      unique case (r.jb)
         JB_OK: begin
            next_r.jb_cnt = MAC_TX_EN ? r.jb_cnt + 32'h1 : 32'h0;
            if (MAC_TX_EN && r.jb_cnt == 32'(JAB_CYC - 1)) begin
               next_r.jb = JB_CUT;
               next_r.jb_cnt = 32'h0;
            end
         end
         JB_CUT: begin
            if (!MAC_TX_EN) begin
               next_r.jb = JB_UNJAB;
            end
         end
         JB_UNJAB: begin
            next_r.jb_cnt = r.jb_cnt + 32'h1;
            if (MAC_TX_EN) begin
               next_r.jb = JB_CUT;
               next_r.jb_cnt = 32'h0;
            end else if (r.jb_cnt == 32'(UNJ_CYC - 1)) begin
               next_r.jb = JB_OK;
               next_r.jb_cnt = 32'h0;
            end
         end
         default: next_r.jb = JB_OK;
      endcase
      if (SPEED_100) begin
         next_r.jb = JB_OK;
         next_r.jb_cnt = 32'h0;
      end
      // crossover: sweep alternates pairs every 256 cycles (not in fast mode) until XOVR_DONE
      if (!r.phc[`PLMC_PHC_AXEN] || fiber_mode_strap) begin
         next_r.xo_sel = r.phc[`PLMC_PHC_XSEL];
         next_r.xo_cnt = 11'h0;
      end else if (!XOVR_DONE) begin
         next_r.xo_cnt = r.xo_cnt + 11'h1;
         if (r.xo_cnt[7:0] == 8'hff && !r.cr1[`PLMC_CR1_FASTX]) begin
            next_r.xo_sel = !r.xo_sel;
         end
      end
      // mii loop: nibble returned one cycle later
      next_r.rxdv = LOOP_MODE == LB_MII && MAC_TX_EN;
      next_r.rxd = next_r.rxdv ? MAC_TXD : 4'h0;
      if (SRST) begin
         next_r = '0;
         next_r.bmc = `PLMC_BMC_RST;
         next_r.cr1 = `PLMC_CR1_RST;
         next_r.stl = `PLMC_STL_RST;
         next_r.phc = `PLMC_PHC_RST;
         next_r.fgc = `PLMC_FGC_RST;
         next_r.sq = SQ_IDLE;
         next_r.jb = JB_OK;
      end
   end

   always_ff @(posedge CLK) begin
      r <= next_r;
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      unique case (REG_ADDR)
         `PLMC_ADDR_BMC: REG_RDATA = r.bmc;
         `PLMC_ADDR_CR1: REG_RDATA = r.cr1;
         `PLMC_ADDR_STL: REG_RDATA = r.stl;
         `PLMC_ADDR_PHC: REG_RDATA = r.phc;
         `PLMC_ADDR_FGC: REG_RDATA = r.fgc;
         default: REG_RDATA = 16'h0000;
      endcase
   end

   // loopback priority picks one point even if several bits set
   always_comb begin
      LOOP_MODE = LB_NONE;
      if (r.bmc[`PLMC_BMC_LOOP]) begin
         LOOP_MODE = LB_MII;
      end else if (r.stl[`PLMC_STL_PCSI]) begin
         LOOP_MODE = LB_PCSI;
      end else if (r.stl[`PLMC_STL_PCSO]) begin
         LOOP_MODE = LB_PCSO;
      end else if (r.stl[`PLMC_STL_DIG]) begin
         LOOP_MODE = LB_DIG;
      end else if (r.stl[`PLMC_STL_ANA] && !fiber_mode_strap) begin
         LOOP_MODE = LB_ANA;
      end else if (r.stl[`PLMC_STL_FAR]) begin
         LOOP_MODE = LB_FAR;
      end
   end

   // line-side outputs
   assign BYPASS_SCRAMBLE = fiber_mode_strap;
   assign BYPASS_MLT3 = fiber_mode_strap;
   assign SECOND_LED_PIN_O = 1'b0;
   assign SECOND_LED_PIN_OE = !signal_detect_strap;
   assign SIGNAL_DETECT = signal_detect_strap &&
      (r.led_sync[1] ^ r.fgc[`PLMC_FGC_SDPOL]);
   assign RX_VALID_10 = r.sq == SQ_VALID;
   assign POL_REVERSED = r.sq_pol;
   assign LINK_PULSE = r.lp_w != 4'h0;
   assign JABBER = r.jb != JB_OK;
   assign TX_ALLOWED = r.jb == JB_OK;
   assign AN_ENABLE = r.bmc[`PLMC_BMC_ANEN] && !fiber_mode_strap;
   assign AN_ABILITY = fiber_mode_strap ? 2'b00 : 2'b11;
   // forced pairing follows the register at once, no one-cycle lag
   assign MDI_CROSS = (!r.phc[`PLMC_PHC_AXEN] || fiber_mode_strap) ?
      r.phc[`PLMC_PHC_XSEL] : r.xo_sel;
   assign XOVR_DONE = !r.phc[`PLMC_PHC_AXEN] || fiber_mode_strap ||
      (r.xo_cnt >= (r.cr1[`PLMC_CR1_FASTX] ? 11'(`PLMC_XOVR_FAST)
                                           : 11'(`PLMC_XOVR_CYC)));
   assign MAC_RX_DV = r.rxdv;
   assign MAC_RXD = r.rxd;
endmodule // plmc_top

/* verif/plmc_asserts.sv */
// assertions on the ports of the line mode and loopback block
`timescale 1ns/100ps
module plmc_asserts
   import plmc_pkg::*;
(
   input wire logic CLK, // clock
   input wire logic SRST, // reset
   input wire logic [15:0] REG_ADDR, // address
   input wire logic [15:0] REG_RDATA, // read data
   input wire logic SPEED_100, // speed
   input wire logic MAC_TX_EN, // tx enable
   input wire logic [3:0] MAC_TXD, // tx nibble
   input wire logic MAC_RX_DV, // rx valid
   input wire logic [3:0] MAC_RXD, // rx nibble
   input wire logic LINK_PULSE, // pulse
   input wire logic TX_ALLOWED, // tx on
   input wire logic JABBER, // cut off
   input wire logic BYPASS_SCRAMBLE, // fiber path
   input wire logic BYPASS_MLT3, // fiber path
   input wire logic AN_ENABLE, // negotiation
   input wire logic [1:0] AN_ABILITY, // offered
   input wire logic MDI_CROSS, // pairing
   input wire logic [2:0] LOOP_MODE // loop point
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   // loopback and register relations
   a_mii_copy: assert property (
      LOOP_MODE == LB_MII && MAC_TX_EN |=> MAC_RX_DV
      && MAC_RXD == $past(MAC_TXD)) else $error("mii loop copy wrong");
   a_mii_first: assert property (
      REG_ADDR == 16'h0000 && REG_RDATA[14] |-> LOOP_MODE == LB_MII)
      else $error("mii loop not selected");
   a_forced_pair: assert property (
      REG_ADDR == 16'h0019 && !REG_RDATA[15] |-> MDI_CROSS == REG_RDATA[14])
      else $error("forced pairing wrong");
   a_an_bit: assert property (
      REG_ADDR == 16'h0000 && !BYPASS_SCRAMBLE |-> AN_ENABLE == REG_RDATA[12])
      else $error("negotiation enable wrong");
   // fiber path and negotiation offer
   a_bypass_pair: assert property (BYPASS_SCRAMBLE == BYPASS_MLT3)
      else $error("bypass flags differ");
   a_fiber_no_an: assert property (BYPASS_SCRAMBLE |-> !AN_ENABLE)
      else $error("negotiation in fiber");
   a_an_offer: assert property (
      !BYPASS_SCRAMBLE |-> AN_ABILITY == 2'b11) else $error("offer wrong");
   // jabber protection
   a_jab_speed: assert property (
      SPEED_100 && $past(SPEED_100) |-> !JABBER) else $error("jabber at 100");
   a_jab_hold: assert property (
      JABBER && MAC_TX_EN && !SPEED_100 |=> JABBER)
      else $error("jabber released early");
   a_jab_cut: assert property (JABBER |-> !TX_ALLOWED)
      else $error("transmit on in jabber");
   a_jab_cause: assert property (
      $fell(TX_ALLOWED) |-> $past(MAC_TX_EN) && !$past(SPEED_100))
      else $error("transmit cut without cause");
   // link pulses: two cycles wide, only when idle on twisted pair
   a_pulse_width: assert property (
      $rose(LINK_PULSE) |=> LINK_PULSE ##1 !LINK_PULSE)
      else $error("link pulse width wrong");
   a_pulse_cause: assert property (
      $rose(LINK_PULSE) |-> !$past(MAC_TX_EN) && !$past(SPEED_100)
      && !BYPASS_MLT3) else $error("link pulse out of place");
endmodule // plmc_asserts
bind plmc_top plmc_asserts u_chk (.CLK(CLK), .SRST(SRST),
   .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA), .SPEED_100(SPEED_100),
   .MAC_TX_EN(MAC_TX_EN), .MAC_TXD(MAC_TXD), .MAC_RX_DV(MAC_RX_DV),
   .MAC_RXD(MAC_RXD), .LINK_PULSE(LINK_PULSE), .TX_ALLOWED(TX_ALLOWED),
   .JABBER(JABBER), .BYPASS_SCRAMBLE(BYPASS_SCRAMBLE),
   .BYPASS_MLT3(BYPASS_MLT3), .AN_ENABLE(AN_ENABLE),
   .AN_ABILITY(AN_ABILITY), .MDI_CROSS(MDI_CROSS), .LOOP_MODE(LOOP_MODE));

/* verif/plmc_mac_model.sv */
// mac and serializer stand-in on the transmit side
`timescale 1ns/100ps
module plmc_mac_model (
   input wire logic clk, // clock
   input wire logic stall, // hold off codes
   output logic tx_en, // transmit enable
   output logic [3:0] txd, // transmit nibble
   input wire logic [4:0] code, // line code
   input wire logic code_valid, // code present
   input wire logic allowed, // transmitter on
   output logic code_ready // code taken
);
   logic [4:0] got[$]; // codes in arrival order
   initial begin
      tx_en = 1'b0;
      txd = 4'h0;
      code_ready = 1'b0;
   end
   // take codes; idle nibble keeps moving so stale data is never trusted
   always @(posedge clk) begin
      if (code_ready && code_valid && allowed) begin
         got.push_back(code);
      end
      if (!tx_en) begin
         txd <= ~txd;
      end
      code_ready <= !stall;
   end
   // one nibble per clock, changed just after the edge
   task automatic drive(input logic e, input logic [3:0] d);
      @(posedge clk);
      #2;
      tx_en = e;
      txd = d;
   endtask
endmodule // plmc_mac_model

/* verif/plmc_top_bench.sv */
// self-checking bench for the line mode and loopback block
`timescale 1ns/100ps
module plmc_top_bench;
   import plmc_pkg::*;
   logic clk, srst, an_strap, reg_wr, speed_100, led_i, sq_pos, sq_neg;
   logic stall, tx_en, rx_dv, code_valid, code_ready, tx_full, led_o, pol_rev;
   logic led_oe, sig_det, rx_valid_10, link_pulse, tx_allowed, sd_drv;
   logic jabber, byp_scr, byp_mlt, autoneg_strap, mdi_cross, xovr_done, f, prev;
   logic [1:0] fm_strap, xo_strap, an_ab;
   logic [2:0] loop_mode;
   logic [3:0] txd, rxd;
   logic [3:0] nib[4];
   logic [4:0] code;
   logic [15:0] reg_addr, reg_wdata, reg_rdata;
   logic [31:0] r;
   integer seed;
   int i, cnt, err_count, checks_done;
   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // pin level: device when enabled, else the optical module
   assign led_i = led_oe ? led_o : sd_drv;
   plmc_top #(.LPI_CYC(50), .JAB_CYC(200), .UNJ_CYC(300)) dut (
      .CLK(clk), .SRST(srst), .FIBER_MODE_STRAP(fm_strap),
      .CROSSOVER_STRAP(xo_strap), .AUTONEG_STRAP(an_strap), .REG_WR(reg_wr),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
      .SPEED_100(speed_100), .MAC_TX_EN(tx_en), .MAC_TXD(txd),
      .MAC_RX_DV(rx_dv), .MAC_RXD(rxd), .TX_CODE(code),
      .TX_CODE_VALID(code_valid), .TX_CODE_READY(code_ready),
      .TX_FULL(tx_full), .SECOND_LED_PIN_I(led_i), .SECOND_LED_PIN_O(led_o),
      .SECOND_LED_PIN_OE(led_oe), .SIGNAL_DETECT(sig_det), .SQ_POS(sq_pos),
      .SQ_NEG(sq_neg), .RX_VALID_10(rx_valid_10), .POL_REVERSED(pol_rev),
      .LINK_PULSE(link_pulse), .TX_ALLOWED(tx_allowed), .JABBER(jabber),
      .BYPASS_SCRAMBLE(byp_scr), .BYPASS_MLT3(byp_mlt), .AN_ENABLE(autoneg_strap),
      .AN_ABILITY(an_ab), .MDI_CROSS(mdi_cross), .XOVR_DONE(xovr_done),
      .LOOP_MODE(loop_mode));
   plmc_mac_model mac (.clk(clk), .stall(stall), .tx_en(tx_en), .txd(txd),
      .code(code), .code_valid(code_valid), .allowed(tx_allowed),
      .code_ready(code_ready));
   // expected 4b5b data codes
   function automatic logic [4:0] enc(input logic [3:0] n);
      logic [4:0] t[16];
      t = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
         5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
      return t[n];
   endfunction
   // expected loop point for selftest bit k
   function automatic logic [2:0] lb_code(input int k);
      plmc_lb_e t[5];
      t = '{LB_PCSI, LB_PCSO, LB_DIG, LB_ANA, LB_FAR};
      return t[k];
   endfunction
   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // a wait that ran out ends the run
   task automatic bound(input int n, input int lim);
      if (n >= lim) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, n, lim);
         wrap_up();
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   // straps are held through reset and sampled on release
   task automatic do_reset(input logic [1:0] fm, input logic [1:0] xo);
      tick(1);
      srst = 1'b1;
      fm_strap = fm;
      xo_strap = xo;
      tick(8);
      srst = 1'b0;
      tick(2);
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      reg_addr = a;
      tick(1);
      chk(reg_rdata, e);
   endtask
   initial begin
      seed = 32'h1bdb;
      {srst, an_strap, stall, speed_100} = 4'hf;
      {reg_wr, sd_drv, sq_pos, sq_neg, fm_strap, xo_strap} = 8'h00;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
      do_reset(2'b00, 2'b00);
      rd(16'h0000, 16'h1000);
      rd(16'h0009, 16'h0000);
      rd(16'h0016, 16'h0000);
      rd(16'h0019, 16'h0000);
      rd(16'h0465, 16'h0000);
      r = $random(seed);
      wr(16'h0009, r[15:0]);
      rd(16'h0009, r[15:0]);
      wr(16'h0123, r[31:16]);
      rd(16'h0123, 16'h0000);
      chk(an_ab, 2'b11);
      wr(16'h0000, 16'h0000);
      chk(autoneg_strap, 1'b0);
      wr(16'h0019, 16'h4000);
      chk(mdi_cross, 1'b1);
      wr(16'h0019, 16'h0000);
      chk(mdi_cross, 1'b0);
      $display("registers done");
      // fill the code fifo while the serializer stalls, then drain it
      for (i = 0; i < 4; i++) begin
         r = $random(seed);
         nib[i] = r[3:0];
         mac.drive(1'b1, nib[i]);
      end
      mac.drive(1'b0, 4'h0);
      tick(2);
      chk(tx_full, 1'b1);
      stall = 1'b0;
      tick(12);
      chk(16'(mac.got.size()), 16'h0004);
      for (i = 0; i < 4; i++) chk(mac.got[i], enc(nib[i]));
      chk(code_valid, 1'b0);
      $display("fifo done");
      // negotiation and crossover already off before any loop
      for (i = 0; i < 5; i++) begin
         wr(16'h0016, 16'h0001 << i);
         chk(loop_mode, lb_code(i));
      end
      wr(16'h0000, 16'h4000);
      chk(loop_mode, LB_MII);
      rd(16'h0016, 16'h0000);
      wr(16'h0016, 16'h0001);
      rd(16'h0000, 16'h0000);
      wr(16'h0000, 16'h4000);
      r = $random(seed);
      mac.drive(1'b1, r[3:0]);
      tick(1);
      chk(rx_dv, 1'b1);
      chk(rxd, r[3:0]);
      mac.drive(1'b0, 4'h0);
      wr(16'h0000, 16'h0000);
      $display("loopback done");
      // jabber at 10 Mb/s, then none at 100 Mb/s
      speed_100 = 1'b0;
      mac.drive(1'b1, 4'h5);
      tick(190);
      chk(jabber, 1'b0);
      tick(20);
      chk(jabber, 1'b1);
      chk(tx_allowed, 1'b0);
      tick(100);
      chk(tx_allowed, 1'b0);
      mac.drive(1'b0, 4'h0);
      tick(280);
      chk(tx_allowed, 1'b0);
      tick(30);
      chk(tx_allowed, 1'b1);
      speed_100 = 1'b1;
      mac.drive(1'b1, 4'ha);
      tick(250);
      chk(jabber, 1'b0);
      chk(tx_allowed, 1'b1);
      mac.drive(1'b0, 4'h0);
      $display("jabber done");
      // idle link pulses at 10 Mb/s over four intervals
      speed_100 = 1'b0;
      tick(60);
      cnt = 0;
      for (i = 0; i < 200; i++) begin
         prev = link_pulse;
         tick(1);
         if (link_pulse && !prev) cnt++;
      end
      chk(16'(cnt), 16'h0004);
      // squelch: first, opposite, then original crossing, spaced apart
      sq_pos = 1'b1;
      tick(1);
      sq_pos = 1'b0;
      tick(1);
      sq_neg = 1'b1;
      tick(1);
      sq_neg = 1'b0;
      tick(1);
      sq_pos = 1'b1;
      tick(1);
      sq_pos = 1'b0;
      for (i = 0; i < 10 && !rx_valid_10; i++) tick(1);
      bound(i, 10);
      // three opposite-first pulses in idle flip the pair polarity
      for (i = 0; i < 3; i++) begin
         sq_neg = 1'b1;
         tick(1);
         sq_neg = 1'b0;
         tick(3);
      end
      chk(pol_rev, 1'b1);
      $display("10 Mb/s done");
      // every strap level pair: fiber path and signal detect pin
      for (i = 0; i < 16; i++) begin
         do_reset(i[3:2], i[1:0]);
         f = (i[3:2] == 2'd1) || (i[3:2] == 2'd2);
         chk(byp_scr, f);
         chk(byp_mlt, f);
         chk(led_oe, !(f && i[1]));
      end
      do_reset(2'b01, 2'b10);
      sd_drv = 1'b1;
      tick(4);
      chk(sig_det, 1'b1);
      wr(16'h0465, 16'h0001);
      chk(sig_det, 1'b0);
      $display("fiber done");
      // automatic crossover from strap resolves in its full time
      do_reset(2'b00, 2'b10);
      rd(16'h0019, 16'h8000);
      for (i = 0; i < 1100 && !xovr_done; i++) tick(1);
      bound(i, 1100);
      chk(i >= 1000, 1'b1);
      // fast resolution ends far sooner
      do_reset(2'b00, 2'b10);
      wr(16'h0009, 16'h0040);
      for (i = 0; i < 300 && !xovr_done; i++) tick(1);
      bound(i, 300);
      chk(i < 200, 1'b1);
      $display("crossover done");
      wrap_up();
   end
endmodule // plmc_top_bench
